// ---- cfcbt_cfg.svh ----
// Purpose: constants for the fault confinement and bit timing block
// Assumes: 32-bit avalon-mm slave, byte addresses, one word per register
// Notes: register offsets, the cfg2 and opt2 field positions and the limits live here; reset values are in the core
`ifndef CFCBT_CFG_SVH
`define CFCBT_CFG_SVH
// ==========================================================================
// register map (byte addresses)
`define CFCBT_ADDR_TX_CNT 6'h00
`define CFCBT_ADDR_RX_CNT 6'h04
`define CFCBT_ADDR_ERR_FLAG 6'h08
`define CFCBT_ADDR_CFG1 6'h0C
`define CFCBT_ADDR_CFG2 6'h10
`define CFCBT_ADDR_CFG3 6'h14
`define CFCBT_ADDR_OPT2 6'h18
`define CFCBT_ADDR_CRC 6'h1C
// ==========================================================================
// field positions
`define CFCBT_CFG2_PHSRC 7
`define CFCBT_CFG2_TRIPLE 6
`define CFCBT_OPT2_RLSEL 0
// ==========================================================================
// limits and timing
`define CFCBT_PASSIVE_LIMIT 9'h080
`define CFCBT_BUSOFF_LIMIT 9'h100
`define CFCBT_IDLE_BITS 4'hB
`define CFCBT_RECOVER_COUNT 8'h80
`define CFCBT_PROC_LEN 4'h2
`define CFCBT_CRC_POLY 15'h4599
`define CFCBT_UNMAPPED_DATA 32'h0000_0000
`endif

// ---- cfcbt_pkg.sv ----
// Purpose: shared types for the fault confinement and bit timing block
// Assumes: nothing beyond the cfg header
// Notes: one-hot state codes written out
package cfcbt_pkg;
  // ========================================================================
  // fault confinement states
  typedef enum logic [2:0] {
    CFCBT_ERR_ACTIVE = 3'b001,
    CFCBT_ERR_PASSIVE = 3'b010,
    CFCBT_BUS_OFF = 3'b100
  } cfcbt_err_t;
  // bit timer segments
  typedef enum logic [3:0] {
    CFCBT_SEG_SYNC = 4'b0001,
    CFCBT_SEG_PROP = 4'b0010,
    CFCBT_SEG_PH1 = 4'b0100,
    CFCBT_SEG_PH2 = 4'b1000
  } cfcbt_seg_t;
  // counter commands from the bit stream processor
  typedef enum logic [2:0] {
    CFCBT_CMD_NONE = 3'h0,
    CFCBT_CMD_TX_ERR = 3'h1,
    CFCBT_CMD_TX_OK = 3'h2,
    CFCBT_CMD_RX_ERR = 3'h3,
    CFCBT_CMD_RX_ERR8 = 3'h4,
    CFCBT_CMD_RX_OK = 3'h5
  } cfcbt_cmd_t;
endpackage : cfcbt_pkg

// ---- cfcbt_core.sv ----
// Purpose: crc, fault confinement counters and bit timer of a can controller
// Assumes: avalon-mm slave with waitrequest, one clock, async active-low reset
// Notes: frame sequencing lives outside; it drives counter commands and crc
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`include "cfcbt_cfg.svh"

// Operation
// RULE_01: crc generated for transmit, checked on receive
// RULE_02: counters move only on processor commands
// RULE_03: both counters below 128 means error-active
// RULE_04: either counter at 128 means error-passive
// RULE_05: transmit count 256 enters and holds bus-off
// RULE_06: 128 runs of 11 recessive bits recover
// RULE_07: recovery listen select gives listen-only recovery
// RULE_08: error flag register shows active or passive
// RULE_09: counters eight bit, read-only, reset zero
// RULE_10: hard sync at frame start, resync otherwise
// RULE_11: quantum is two clocks times prescaler plus one
// RULE_12: software keeps bit time 8 to 25 quanta
// RULE_13: bit time is four segments in quanta
// RULE_14: software keeps segment ordering constraints
// RULE_15: sync segment is one quantum
// RULE_16: propagation segment 1 to 8 quanta
// RULE_17: phase one 1 to 8, ends at sample
// RULE_18: phase two at least two quanta
// RULE_19: phase segments adjusted by resynchronization
// RULE_20: triple sampling half a quantum apart, majority
// RULE_21: processing time fixed two quanta
// RULE_22: jump width code n gives n+1 quanta
// RULE_23: early edge lengthens one, late shortens two
// RULE_24: phase two source select picks length
// RULE_25: triple sample select enables majority detection
// RULE_26: standard increments, no rx underflow, tx holds
module cfcbt_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // can pins
  input wire logic can_rx,
  output logic can_tx,
  // bit stream processor side
  input wire logic [2:0] bsp_cmd,
  input wire logic bsp_tx_bit,
  input wire logic bsp_sof,
  input wire logic bsp_crc_init,
  input wire logic bsp_crc_shift,
  input wire logic bsp_crc_bit,
  // status outputs
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic listen_only,
  output logic [14:0] crc_value
);
  // ========================================================================
  // declarations
  logic rx_meta_ff, rx_sync_ff, rx_prev_ff; // input synchroniser
  logic [7:0] tx_error_count_ff; // transmit error count
  logic tx_over_ff; // transmit count passed 255
  logic [7:0] rx_error_count_ff; // receive error count
  cfcbt_pkg::cfcbt_err_t err_state_ff; // confinement state
  logic [7:0] bit_timing_cfg_one_ff, bit_timing_cfg_two_ff, bit_timing_cfg_three_ff;
  logic [7:0] option_register_two_ff;
  logic [14:0] crc_ff; // crc shift register
  logic [6:0] pre_cnt_ff; // half-quantum divider
  logic half_ff; // which half of quantum
  logic [3:0] tq_cnt_ff; // quantum within segment
  logic [4:0] ph1_len_ff, ph2_len_ff; // adjusted phase lengths
  cfcbt_pkg::cfcbt_seg_t seg_ff;
  logic s1_ff, s2_ff; // early samples for triple mode
  logic [3:0] idle_cnt_ff; // recessive bit run
  logic [7:0] recov_cnt_ff; // recovery runs seen
  logic ack_ff; // bus handshake phase
  logic hit_tq, hit_half, edge_seen, sample_pt, bit_end;
  logic [4:0] prop_len, ph1_cfg, ph2_cfg, jump_len;
  logic [8:0] tx_cnt_ext, rx_cnt_ext; // counters at nine bits, tx with its overflow bit, rx zero-padded
  logic resync_ok, early_edge; // edge allowed to move the bit timer
  // ========================================================================
  // helper functions
  function automatic logic [4:0] len_of(input logic [2:0] code);
    len_of = {2'b00, code} + 5'h01;
  endfunction : len_of
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3
  // ========================================================================
  // receive input synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= can_rx;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end
  assign edge_seen = rx_prev_ff & ~rx_sync_ff; // recessive to dominant
  // ========================================================================
  // avalon slave: one wait cycle, then answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_ff);
    end
  end
  // configuration registers, written on the accepting edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_timing_cfg_one_ff <= 8'h00;
      bit_timing_cfg_two_ff <= 8'h00;
      bit_timing_cfg_three_ff <= 8'h01;
      option_register_two_ff <= 8'h00;
    end else if (avs_write && ack_ff) begin
      case (avs_address)
        `CFCBT_ADDR_CFG1: bit_timing_cfg_one_ff <= avs_writedata[7:0];
        `CFCBT_ADDR_CFG2: bit_timing_cfg_two_ff <= avs_writedata[7:0];
        `CFCBT_ADDR_CFG3: bit_timing_cfg_three_ff <= {1'b0, avs_writedata[6], 3'b000,
                                                      avs_writedata[2:0]};
        `CFCBT_ADDR_OPT2: option_register_two_ff <= avs_writedata[7:0];
        default: ; // read-only or unmapped: ignored
      endcase
    end
  end
  // read mux; counters are read-only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      case (avs_address)
        `CFCBT_ADDR_TX_CNT: avs_readdata <= {24'h00_0000, tx_error_count_ff}; // see RULE_09
        `CFCBT_ADDR_RX_CNT: avs_readdata <= {24'h00_0000, rx_error_count_ff}; // see RULE_09
        // bit0 error-passive state flags: bit3 tx passive, bit4 rx passive, bit5 bus-off
        `CFCBT_ADDR_ERR_FLAG: avs_readdata <= {26'h000_0000, tx_over_ff,
            rx_cnt_ext >= `CFCBT_PASSIVE_LIMIT, tx_cnt_ext >= `CFCBT_PASSIVE_LIMIT,
            2'b00, err_state_ff == cfcbt_pkg::CFCBT_ERR_PASSIVE}; // see RULE_08
        `CFCBT_ADDR_CFG1: avs_readdata <= {24'h00_0000, bit_timing_cfg_one_ff};
        `CFCBT_ADDR_CFG2: avs_readdata <= {24'h00_0000, bit_timing_cfg_two_ff};
        `CFCBT_ADDR_CFG3: avs_readdata <= {24'h00_0000, bit_timing_cfg_three_ff};
        `CFCBT_ADDR_OPT2: avs_readdata <= {24'h00_0000, option_register_two_ff};
        `CFCBT_ADDR_CRC: avs_readdata <= {17'h0_0000, crc_ff};
        default: avs_readdata <= `CFCBT_UNMAPPED_DATA;
      endcase
    end
  end
  // ========================================================================
  // crc: same register for send and check
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_ff <= 15'h0000;
    end else if (bsp_crc_init) begin
      crc_ff <= 15'h0000;
    end else if (bsp_crc_shift) begin
      // shift over stuff-free bits up to control or data end, see RULE_01
      crc_ff <= {crc_ff[13:0], 1'b0} ^ ((bsp_crc_bit ^ crc_ff[14]) ? `CFCBT_CRC_POLY : 15'h0000);
    end
  end
  // ========================================================================
  // error counters, stepped only by commands
  assign tx_cnt_ext = {tx_over_ff, tx_error_count_ff};
  assign rx_cnt_ext = {1'b0, rx_error_count_ff};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_error_count_ff <= 8'h00;
      tx_over_ff <= 1'b0;
    end else if (err_state_ff == cfcbt_pkg::CFCBT_BUS_OFF) begin
      if (recov_cnt_ff == `CFCBT_RECOVER_COUNT) begin
        tx_error_count_ff <= 8'h00; // recovery clears, see RULE_26
        tx_over_ff <= 1'b0;
      end
    end else begin
      case (cfcbt_pkg::cfcbt_cmd_t'(bsp_cmd)) // see RULE_02
        cfcbt_pkg::CFCBT_CMD_TX_ERR: {tx_over_ff, tx_error_count_ff} <= tx_cnt_ext + 9'h008;
        cfcbt_pkg::CFCBT_CMD_TX_OK:
          if (tx_cnt_ext != 9'h000) tx_error_count_ff <= tx_error_count_ff - 8'h01;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_error_count_ff <= 8'h00;
    end else if (err_state_ff == cfcbt_pkg::CFCBT_BUS_OFF) begin
      if (recov_cnt_ff == `CFCBT_RECOVER_COUNT) rx_error_count_ff <= 8'h00;
    end else begin
      case (cfcbt_pkg::cfcbt_cmd_t'(bsp_cmd)) // see RULE_02
        cfcbt_pkg::CFCBT_CMD_RX_ERR:
          if (rx_error_count_ff != 8'hFF) rx_error_count_ff <= rx_error_count_ff + 8'h01;
        cfcbt_pkg::CFCBT_CMD_RX_ERR8:
          rx_error_count_ff <= (rx_error_count_ff > 8'hF7) ? 8'hFF : rx_error_count_ff + 8'h08;
        cfcbt_pkg::CFCBT_CMD_RX_OK: // no wrap below zero, see RULE_26
          if (rx_error_count_ff > 8'h7F) rx_error_count_ff <= 8'h78;
          else if (rx_error_count_ff != 8'h00) rx_error_count_ff <= rx_error_count_ff - 8'h01;
        default: ;
      endcase
    end
  end
  // ========================================================================
  // confinement state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_state_ff <= cfcbt_pkg::CFCBT_ERR_ACTIVE;
    end else begin
      case (err_state_ff)
        cfcbt_pkg::CFCBT_BUS_OFF:
          if (recov_cnt_ff == `CFCBT_RECOVER_COUNT)
            err_state_ff <= cfcbt_pkg::CFCBT_ERR_ACTIVE; // see RULE_06
        default:
          if (tx_cnt_ext >= `CFCBT_BUSOFF_LIMIT) err_state_ff <= cfcbt_pkg::CFCBT_BUS_OFF; // see RULE_05
          else if (tx_cnt_ext >= `CFCBT_PASSIVE_LIMIT || rx_cnt_ext >= `CFCBT_PASSIVE_LIMIT)
            err_state_ff <= cfcbt_pkg::CFCBT_ERR_PASSIVE; // see RULE_04
          else err_state_ff <= cfcbt_pkg::CFCBT_ERR_ACTIVE; // see RULE_03
      endcase
    end
  end
  // recovery: count runs of recessive bits while bus-off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_ff <= 4'h0;
      recov_cnt_ff <= 8'h00;
    end else if (err_state_ff != cfcbt_pkg::CFCBT_BUS_OFF) begin
      idle_cnt_ff <= 4'h0;
      recov_cnt_ff <= 8'h00;
    end else if (sample_pt) begin
      if (!rx_sync_ff) idle_cnt_ff <= 4'h0;
      else if (idle_cnt_ff == `CFCBT_IDLE_BITS - 4'h1) begin
        idle_cnt_ff <= 4'h0;
        recov_cnt_ff <= recov_cnt_ff + 8'h01; // see RULE_06
      end else idle_cnt_ff <= idle_cnt_ff + 4'h1;
    end
  end
  // listen-only while recovering, transmitter silenced in bus-off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      listen_only <= 1'b0;
      can_tx <= 1'b1;
    end else begin
      listen_only <= (err_state_ff == cfcbt_pkg::CFCBT_BUS_OFF) &&
                     option_register_two_ff[`CFCBT_OPT2_RLSEL]; // see RULE_07
      can_tx <= (err_state_ff == cfcbt_pkg::CFCBT_BUS_OFF) ? 1'b1 : bsp_tx_bit;
    end
  end
  // ========================================================================
  // bit timer: half-quantum tick from the prescaler
  assign hit_half = pre_cnt_ff == {1'b0, bit_timing_cfg_one_ff[5:0]};
  assign hit_tq = hit_half & half_ff; // two ticks per quantum, see RULE_11
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_ff <= 7'h00;
      half_ff <= 1'b0;
    end else if (bsp_sof && edge_seen) begin
      pre_cnt_ff <= 7'h00; // hard sync restarts quantum
      half_ff <= 1'b0;
    end else if (hit_half) begin
      pre_cnt_ff <= 7'h00;
      half_ff <= ~half_ff;
    end else pre_cnt_ff <= pre_cnt_ff + 7'h01;
  end
  assign prop_len = len_of(bit_timing_cfg_two_ff[2:0]); // see RULE_16
  assign ph1_cfg = len_of(bit_timing_cfg_two_ff[5:3]); // see RULE_17
  assign jump_len = len_of({1'b0, bit_timing_cfg_one_ff[7:6]}); // see RULE_22
  // resync only when not sending dominant
  assign resync_ok = edge_seen && !(bsp_tx_bit == 1'b0 && !listen_only); // see RULE_10
  assign early_edge = resync_ok && (seg_ff == cfcbt_pkg::CFCBT_SEG_PROP ||
                                    seg_ff == cfcbt_pkg::CFCBT_SEG_PH1);
  // phase two length, never under two quanta, see RULE_24
  assign ph2_cfg = bit_timing_cfg_two_ff[`CFCBT_CFG2_PHSRC] ?
      ((len_of(bit_timing_cfg_three_ff[2:0]) < {1'b0, `CFCBT_PROC_LEN}) ? {1'b0, `CFCBT_PROC_LEN}
        : len_of(bit_timing_cfg_three_ff[2:0])) // see RULE_18
      : ((ph1_cfg > {1'b0, `CFCBT_PROC_LEN}) ? ph1_cfg : {1'b0, `CFCBT_PROC_LEN}); // see RULE_21
  assign sample_pt = hit_tq && seg_ff == cfcbt_pkg::CFCBT_SEG_PH1 &&
                     {1'b0, tq_cnt_ff} + 5'h01 >= ph1_len_ff;
  assign bit_end = hit_tq && seg_ff == cfcbt_pkg::CFCBT_SEG_PH2 &&
                   {1'b0, tq_cnt_ff} + 5'h01 >= ph2_len_ff;
  // segment sequencer with resynchronization
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_ff <= cfcbt_pkg::CFCBT_SEG_SYNC;
      tq_cnt_ff <= 4'h0;
      ph1_len_ff <= 5'h01;
      ph2_len_ff <= 5'h02;
    end else if (bsp_sof && edge_seen) begin
      seg_ff <= cfcbt_pkg::CFCBT_SEG_SYNC; // hard sync, see RULE_10
      tq_cnt_ff <= 4'h0;
      ph1_len_ff <= ph1_cfg;
      ph2_len_ff <= ph2_cfg;
    end else if (resync_ok && seg_ff == cfcbt_pkg::CFCBT_SEG_PH2) begin
      seg_ff <= cfcbt_pkg::CFCBT_SEG_SYNC; // late edge cuts phase two, see RULE_19
      tq_cnt_ff <= 4'h0;
      ph1_len_ff <= ph1_cfg;
    end else if (early_edge && !hit_tq) begin
      ph1_len_ff <= ph1_cfg + jump_len; // early edge stretches phase one, see RULE_23
    end else if (hit_tq) begin
      // an early edge on a quantum tick must not swallow the tick
      if (early_edge) ph1_len_ff <= ph1_cfg + jump_len; // see RULE_23
      case (seg_ff) // see RULE_13
        cfcbt_pkg::CFCBT_SEG_SYNC: begin
          seg_ff <= cfcbt_pkg::CFCBT_SEG_PROP; // one quantum, see RULE_15
          tq_cnt_ff <= 4'h0;
        end
        cfcbt_pkg::CFCBT_SEG_PROP:
          if ({1'b0, tq_cnt_ff} + 5'h01 >= prop_len) begin
            seg_ff <= cfcbt_pkg::CFCBT_SEG_PH1;
            tq_cnt_ff <= 4'h0;
          end else tq_cnt_ff <= tq_cnt_ff + 4'h1;
        cfcbt_pkg::CFCBT_SEG_PH1:
          if (sample_pt) begin
            seg_ff <= cfcbt_pkg::CFCBT_SEG_PH2;
            tq_cnt_ff <= 4'h0;
            ph2_len_ff <= ph2_cfg;
          end else tq_cnt_ff <= tq_cnt_ff + 4'h1;
        cfcbt_pkg::CFCBT_SEG_PH2:
          if (bit_end) begin
            seg_ff <= cfcbt_pkg::CFCBT_SEG_SYNC;
            tq_cnt_ff <= 4'h0;
            ph1_len_ff <= ph1_cfg;
          end else tq_cnt_ff <= tq_cnt_ff + 4'h1;
        default: seg_ff <= cfcbt_pkg::CFCBT_SEG_SYNC;
      endcase
    end
  end
  // early samples each half quantum, majority at sample point
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      rx_bit <= 1'b1;
      rx_bit_valid <= 1'b0;
    end else begin
      if (hit_half) begin
        s1_ff <= s2_ff; // see RULE_20
        s2_ff <= rx_sync_ff;
      end
      rx_bit_valid <= sample_pt;
      if (sample_pt)
        rx_bit <= bit_timing_cfg_two_ff[`CFCBT_CFG2_TRIPLE] ?
                  maj3(s1_ff, s2_ff, rx_sync_ff) : rx_sync_ff; // see RULE_25
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) crc_value <= 15'h0000;
    else crc_value <= crc_ff;
  end
  // ========================================================================
  // assertions
  AST_BUSOFF_ENTRY: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_05
    (tx_cnt_ext >= `CFCBT_BUSOFF_LIMIT && err_state_ff != cfcbt_pkg::CFCBT_BUS_OFF)
      |=> err_state_ff == cfcbt_pkg::CFCBT_BUS_OFF) else $error("bus-off not entered");
  AST_PASSIVE: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_04
    (err_state_ff != cfcbt_pkg::CFCBT_BUS_OFF && tx_cnt_ext < `CFCBT_BUSOFF_LIMIT &&
     rx_cnt_ext >= `CFCBT_PASSIVE_LIMIT) |=> err_state_ff == cfcbt_pkg::CFCBT_ERR_PASSIVE)
    else $error("passive not entered");
  AST_ACTIVE: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_03
    (err_state_ff == cfcbt_pkg::CFCBT_ERR_PASSIVE && tx_cnt_ext < `CFCBT_PASSIVE_LIMIT &&
     rx_cnt_ext < `CFCBT_PASSIVE_LIMIT) |=> err_state_ff == cfcbt_pkg::CFCBT_ERR_ACTIVE)
    else $error("active not restored");
  AST_RECOVER: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_06
    $rose(err_state_ff == cfcbt_pkg::CFCBT_ERR_ACTIVE) && $past(err_state_ff[2])
      |-> $past(recov_cnt_ff) == `CFCBT_RECOVER_COUNT) else $error("early recovery");
  AST_LISTEN: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_07
    (err_state_ff == cfcbt_pkg::CFCBT_BUS_OFF && option_register_two_ff[0]) ##1
      (err_state_ff == cfcbt_pkg::CFCBT_BUS_OFF) |-> listen_only) else $error("not listening");
  AST_SYNC_ONE: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_15
    (hit_tq && seg_ff == cfcbt_pkg::CFCBT_SEG_SYNC && !edge_seen)
      |=> seg_ff == cfcbt_pkg::CFCBT_SEG_PROP) else $error("sync not one quantum");
  AST_PH2_MIN: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_18
    seg_ff == cfcbt_pkg::CFCBT_SEG_PH2 |-> ph2_len_ff >= 5'h02) else $error("phase two short");
  AST_RX_VALID: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_17
    sample_pt |=> rx_bit_valid ##1 !rx_bit_valid) else $error("sample strobe wrong");
endmodule : cfcbt_core

// ---- cfcbt_bus_node.sv ----
// Purpose: the other nodes on the shared can bus, wired-and with the device
// Assumes: dominant is 0, bus rests recessive
// Notes: the bench steers the other nodes through hold_level
module cfcbt_bus_node (
  // clock
  input wire logic clk,
  // device transmit pin
  input wire logic dev_tx,
  // bus level seen by the device
  output logic bus_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic node_drive = 1'b1; // other nodes, recessive at rest
  // any dominant driver wins the bus
  assign bus_rx = dev_tx & node_drive;
  // drive a level for n clocks, then release to recessive
  task automatic hold_level(input logic lvl, input int n);
    @(posedge clk) node_drive <= lvl;
    repeat (n) @(posedge clk);
    node_drive <= 1'b1;
  endtask : hold_level
endmodule : cfcbt_bus_node

// ---- cfcbt_core_test.sv ----
// Purpose: self-checking bench for counters, error states, crc and bit timer
// Assumes: avalon-mm accesses, one wait state, 250 MHz clock
// Notes: recovery runs at a fast bit rate only to keep the run short
`include "cfcbt_cfg.svh"
module cfcbt_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, can_rx, can_tx, rx_bit_valid, rx_bit, listen_only;
  logic [2:0] bsp_cmd = 3'h0;
  logic bsp_tx_bit = 1'b1; // bit the device sends, recessive at rest
  logic bsp_sof = 1'b0; // hard sync permit
  logic bsp_crc_init = 1'b0;
  logic bsp_crc_shift = 1'b0;
  logic bsp_crc_bit = 1'b0;
  logic [14:0] crc_value, crc_exp;
  logic [18:0] pat = 19'h5_A3C6; // crc input bits
  int bad_count = 0, n_tests = 0, cycles = 0;
  always #2 clk = ~clk;
  cfcbt_core dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .can_rx(can_rx),
    .can_tx(can_tx), .bsp_cmd(bsp_cmd), .bsp_tx_bit(bsp_tx_bit), .bsp_sof(bsp_sof),
    .bsp_crc_init(bsp_crc_init), .bsp_crc_shift(bsp_crc_shift), .bsp_crc_bit(bsp_crc_bit),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .listen_only(listen_only),
    .crc_value(crc_value));
  cfcbt_bus_node node_u (.clk(clk), .dev_tx(can_tx), .bus_rx(can_rx));
  // ========================================================================
  // tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdchk
  // command held for n sampling edges
  task automatic cmd(input logic [2:0] c, input int n);
    @(posedge clk) bsp_cmd <= c;
    repeat (n - 1) @(posedge clk);
    @(posedge clk) bsp_cmd <= 3'h0;
  endtask : cmd
  task automatic wait_bit();
    do @(posedge clk); while (rx_bit_valid !== 1'b1);
  endtask : wait_bit
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
    bus(1'b1, `CFCBT_ADDR_CFG1, {24'h00_0000, c1});
    bus(1'b1, `CFCBT_ADDR_CFG2, {24'h00_0000, c2});
    bus(1'b1, `CFCBT_ADDR_CFG3, {24'h00_0000, c3});
  endtask : cfg
  // clocks between two sample points against the expected bit time
  task automatic bit_len(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3,
                         input int e);
    int n;
    cfg(c1, c2, c3);
    repeat (2) wait_bit();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rx_bit_valid !== 1'b1);
    chk("bit clocks", e, n);
  endtask : bit_len
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      finish_test();
    end
  end
  // ========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(`CFCBT_ADDR_TX_CNT, 32'h0000_0000, "tx count");
    rdchk(`CFCBT_ADDR_RX_CNT, 32'h0000_0000, "rx count");
    rdchk(`CFCBT_ADDR_ERR_FLAG, 32'h0000_0000, "flags");
    bus(1'b1, `CFCBT_ADDR_TX_CNT, 32'h0000_00FF);
    rdchk(`CFCBT_ADDR_TX_CNT, 32'h0000_0000, "tx count ro");
    rdchk(6'h3C, 32'h0000_0000, "unmapped");
    // receive counter: no underflow, +1 and +8 steps, passive at 128
    cmd(cfcbt_pkg::CFCBT_CMD_RX_OK, 1);
    rdchk(`CFCBT_ADDR_RX_CNT, 32'h0000_0000, "rx floor");
    cmd(cfcbt_pkg::CFCBT_CMD_RX_ERR, 3);
    cmd(cfcbt_pkg::CFCBT_CMD_RX_ERR8, 15);
    rdchk(`CFCBT_ADDR_RX_CNT, 32'h0000_007B, "rx count");
    rdchk(`CFCBT_ADDR_ERR_FLAG, 32'h0000_0000, "flags");
    cmd(cfcbt_pkg::CFCBT_CMD_RX_ERR, 5);
    rdchk(`CFCBT_ADDR_ERR_FLAG, 32'h0000_0011, "flags");
    // second reset in mid-run clears the counters
    @(posedge clk) reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(`CFCBT_ADDR_RX_CNT, 32'h0000_0000, "rx count");
    cfg(8'h00, 8'h12, 8'h01);
    cmd(cfcbt_pkg::CFCBT_CMD_TX_ERR, 16);
    rdchk(`CFCBT_ADDR_ERR_FLAG, 32'h0000_0009, "flags");
    cmd(cfcbt_pkg::CFCBT_CMD_TX_OK, 1);
    rdchk(`CFCBT_ADDR_TX_CNT, 32'h0000_007F, "tx count");
    rdchk(`CFCBT_ADDR_ERR_FLAG, 32'h0000_0000, "flags");
    cmd(cfcbt_pkg::CFCBT_CMD_TX_ERR, 16);
    rdchk(`CFCBT_ADDR_ERR_FLAG, 32'h0000_0009, "flags at 255");
    // device asks for dominant; bus-off must silence the pin
    bsp_tx_bit <= 1'b0;
    cmd(cfcbt_pkg::CFCBT_CMD_TX_ERR, 1);
    bus(1'b0, `CFCBT_ADDR_ERR_FLAG, 32'h0000_0000);
    chk("bus off flag", 32'h0000_0001, {31'h0, rd[5]});
    bus(1'b1, `CFCBT_ADDR_OPT2, 32'h0000_0001);
    // option lands at the accepting edge, listen_only follows one edge later
    repeat (2) @(posedge clk);
    chk("listen only", 32'h0000_0001, {31'h0, listen_only});
    chk("tx pin", 32'h0000_0001, {31'h0, can_tx});
    bsp_tx_bit <= 1'b1;
    // idle bus for more than 128 runs of 11 recessive bits
    repeat (1450) wait_bit();
    rdchk(`CFCBT_ADDR_ERR_FLAG, 32'h0000_0000, "recovered");
    rdchk(`CFCBT_ADDR_TX_CNT, 32'h0000_0000, "tx count");
    chk("listen only", 32'h0000_0000, {31'h0, listen_only});
    // crc shift register against a reference model
    @(posedge clk) bsp_crc_init <= 1'b1;
    @(posedge clk) bsp_crc_init <= 1'b0;
    crc_exp = 15'h0000;
    for (int i = 18; i >= 0; i--) begin
      bsp_crc_shift <= 1'b1;
      bsp_crc_bit <= pat[i];
      crc_exp = (pat[i] ^ crc_exp[14]) ? {crc_exp[13:0], 1'b0} ^ `CFCBT_CRC_POLY
                                          : {crc_exp[13:0], 1'b0};
      @(posedge clk);
    end
    bsp_crc_shift <= 1'b0;
    repeat (2) @(posedge clk);
    chk("crc", {17'h0_0000, crc_exp}, {17'h0_0000, crc_value});
    // bit times: (1 + prop + ph1 + ph2) quanta of 2 * (prescaler + 1) clocks
    bit_len(8'h0F, 8'h12, 8'h01, 320);
    bit_len(8'h3F, 8'h8B, 8'h01, 1152);
    bit_len(8'h0A, 8'h47, 8'h01, 264);
    // dominant from another node, hard sync permitted, triple sampling on
    bsp_sof <= 1'b1;
    fork
      node_u.hold_level(1'b0, 800);
    join_none
    repeat (2) wait_bit();
    chk("rx dominant", 32'h0000_0000, {31'h0, rx_bit});
    bsp_sof <= 1'b0;
    repeat (4) wait_bit();
    chk("rx recessive", 32'h0000_0001, {31'h0, rx_bit});
    finish_test();
  end
endmodule : cfcbt_core_test
